// ---- rtl/srom_pkg.sv ----
package srom_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_MASTER_RESET = 6'h03;
    localparam logic [5:0] IDX_LP_LOW = 6'h0a;
    localparam logic [5:0] IDX_LP_MID = 6'h0b;
    localparam logic [5:0] IDX_LP_HIGH = 6'h0c;
    localparam logic [5:0] IDX_RE_LOW = 6'h0d;
    localparam logic [5:0] IDX_RE_MID = 6'h0e;
    localparam logic [5:0] IDX_RE_HIGH = 6'h0f;
    localparam logic [5:0] IDX_CTRL = 6'h10;
    localparam logic [5:0] IDX_STATUS = 6'h11;

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    typedef struct packed {
        logic parity_word_mode;
        logic descramble_disable;
        logic force_out_of_frame;
        logic alternate_framing_select;
        logic section_parity_irq_mask;
        logic signal_loss_irq_mask;
        logic frame_loss_irq_mask;
        logic out_of_frame_irq_mask;
    } srom_ctrl_type;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int CTRL_FORCE_OUT_OF_FRAME_POS = 5;
    localparam int EV_B1_POS = 3;
    localparam int EV_LOS_POS = 2;
    localparam int EV_LOF_POS = 1;
    localparam int EV_OOF_POS = 0;
    localparam int CNT_W = 20;

    typedef struct packed {
        logic strobe;
        logic [7:0] data;
        logic bit_in;
    } srom_line_type;

    typedef enum logic [1:0] {
        FR_SEARCH = 2'b01,
        FR_SYNC = 2'b10
    } srom_frm_type;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam logic [7:0] A1_BYTE = 8'hf6;
    localparam logic [7:0] A2_BYTE = 8'h28;
    localparam int ROW_BYTES = 90;
    localparam int FRAME_ROWS = 9;
    localparam logic [11:0] FRAME_LAST_STS1 = 12'(ROW_BYTES * FRAME_ROWS - 1);
    localparam logic [11:0] FRAME_LAST_STS3 = 12'(3 * ROW_BYTES * FRAME_ROWS - 1);
    localparam logic [11:0] B1_POS_STS1 = 12'(ROW_BYTES);
    localparam logic [11:0] B1_POS_STS3 = 12'(3 * ROW_BYTES);
    localparam logic [6:0] SCR_SEED = 7'h7f;
    localparam logic [2:0] OOF_BAD_FRAMES = 3'h4;
    localparam logic [1:0] LOS_CLEAR_WORDS = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int POLL_TIME_NS = 1000;
    localparam int POLL_CYCLES = POLL_TIME_NS * CLK_MHZ / 1000;
    localparam int LOS_TIME_NS = 20000;
    localparam int LOS_CYCLES = LOS_TIME_NS * CLK_MHZ / 1000;
    localparam int LOF_TIME_US = 3000;
    localparam int LOF_CYCLES = LOF_TIME_US * CLK_MHZ;

endpackage

// ---- rtl/srom_top.sv ----
// Behaviour
// - Line parity errors accumulate in a 20-bit counter read over three byte registers.
// - Writing a line parity count address or master reset latches and clears the count.
// - Count transfer completes within 1 us; software reads only after that.
// - Remote error indications accumulate in a separate 20-bit counter, three registers.
// - Remote count write or master reset latches and restarts it within 1 us.
// - Out-of-frame mask set raises section interrupt on out-of-frame change.
// - Frame loss mask set raises section interrupt on frame loss change.
// - Signal loss mask set raises section interrupt on signal loss change.
// - Section parity mask set raises section interrupt on each B1 error.
// - Alternate framing checks only first A1 and first A2 nibble.
// - Default framing checks every A1 and A2 byte.
// - Force-out-of-frame write drops framing at next frame boundary.
// - Byte mode relies on external realignment; bit mode searches internally.
// - Force-out-of-frame is write-only; its read position always returns zero.
// - Descrambler bypassed while descramble disable is one.
// - Word mode flags one B1 error per frame, else every errored bit.
// - Out-of-frame holds until a valid framing pattern is found.
// - Frame loss declares and clears after 3 ms persistence.
// - Signal loss declares after 20 us of consecutive all-zero input.
// - Signal loss clears after two framing words with no zero period between.
// - Out-of-frame and frame loss events set on change, clear on status read.
// - Signal loss and parity events set on change or error, clear on read.
`timescale 1ns/1ps
module srom_top #(
    parameter int LOF_CYCLES = srom_pkg::LOF_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Line side
    input wire logic bit_serial_mode,
    input wire logic sts3_mode,
    input wire srom_pkg::srom_line_type line_in,
    input wire logic line_parity_err,
    input wire logic remote_error,
    // Receive stream and alarms
    output logic [7:0] rx_data_out,
    output logic rx_data_valid,
    output logic out_of_frame,
    output logic frame_loss,
    output logic signal_loss,
    output logic section_parity_error_out,
    output logic section_irq
);

    localparam int LOF_W = $clog2(LOF_CYCLES + 1);
    localparam int LOS_W = $clog2(srom_pkg::LOS_CYCLES + 1);

    if (LOF_CYCLES < 2) begin : g_bad_lof
        $error("LOF_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [14:0] scr_step(input logic [6:0] s);
        logic [6:0] st;
        logic [7:0] k;
        st = s;
        k = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            k[i] = st[6];
            st = {st[5:0], st[6] ^ st[5]};
        end
        return {st, k};
    endfunction

    function automatic logic [3:0] popcnt(input logic [7:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++) begin
            c = c + {3'h0, v[i]};
        end
        return c;
    endfunction

    function automatic logic [srom_pkg::CNT_W-1:0] sat_inc(input logic [srom_pkg::CNT_W-1:0] c, input logic e);
        return (e && c != {srom_pkg::CNT_W{1'b1}}) ? c + 1'b1 : c;
    endfunction

    function automatic logic is_lp(input logic [5:0] i);
        return i == srom_pkg::IDX_LP_LOW || i == srom_pkg::IDX_LP_MID || i == srom_pkg::IDX_LP_HIGH;
    endfunction

    function automatic logic is_re(input logic [5:0] i);
        return i == srom_pkg::IDX_RE_LOW || i == srom_pkg::IDX_RE_MID || i == srom_pkg::IDX_RE_HIGH;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    srom_pkg::srom_frm_type st_r, st_nxt;
    srom_pkg::srom_ctrl_type ctrl_r;
    logic [11:0] pos_r;
    logic [7:0] prev_r;
    logic [15:0] bsr_r;
    logic [2:0] ph_r;
    logic fbad_r;
    logic [2:0] badcnt_r;
    logic force_out_of_frame_r;
    logic [6:0] scr_r;
    logic [7:0] bip_acc_r, bip_prev_r;
    logic bip_arm_r, bip_ok_r;
    logic [3:0] b1pend_r;
    logic [LOS_W-1:0] zrun_r;
    logic [1:0] loscnt_r;
    logic [LOF_W-1:0] lofcnt_r;
    logic [3:0] ev_r;
    logic [3:0] snap_r;
    logic [srom_pkg::CNT_W-1:0] lp_cnt_r, lp_hold_r, re_cnt_r, re_hold_r;
    logic oof_r, lof_r, los_r;

    // ------------------------------------------------------------
    // Byte assembly and framing
    // ------------------------------------------------------------
    wire logic searching = st_r == srom_pkg::FR_SEARCH;
    wire logic syncd = st_r == srom_pkg::FR_SYNC;
    wire logic [15:0] bwin = {bsr_r[14:0], line_in.bit_in};
    wire logic [15:0] pat = {srom_pkg::A1_BYTE, srom_pkg::A2_BYTE};
    // While searching in bit mode a pattern match in the bit window forces a byte boundary
    wire logic bit_hit = searching & (bwin == pat);
    wire logic stb = line_in.strobe & (~bit_serial_mode | ph_r == 3'h7 | bit_hit);
    wire logic [7:0] cur = bit_serial_mode ? bwin[7:0] : line_in.data;
    wire logic [15:0] win = bit_serial_mode ? bwin : {prev_r, cur};
    wire logic hit = stb & searching & (win == pat);
    wire logic [11:0] nn = sts3_mode ? 12'h003 : 12'h001;
    wire logic [11:0] a2_last = (nn << 1) - 12'h001;
    wire logic [11:0] soh_end = nn + (nn << 1);
    wire logic [11:0] last_pos = sts3_mode ? srom_pkg::FRAME_LAST_STS3 : srom_pkg::FRAME_LAST_STS1;
    wire logic [11:0] b1_pos = sts3_mode ? srom_pkg::B1_POS_STS3 : srom_pkg::B1_POS_STS1;
    wire logic frame_end = stb & pos_r == last_pos;
    wire logic in_a1 = pos_r < nn;
    wire logic in_a2 = pos_r >= nn && pos_r <= a2_last;
    wire logic bad_alt = (pos_r == 12'h000 && cur != srom_pkg::A1_BYTE) ||
                         (pos_r == nn && cur[7:4] != srom_pkg::A2_BYTE[7:4]);
    wire logic bad_all = (in_a1 && cur != srom_pkg::A1_BYTE) || (in_a2 && cur != srom_pkg::A2_BYTE);
    wire logic byte_bad = ctrl_r.alternate_framing_select ? bad_alt : bad_all;
    wire logic fw_end = stb & syncd & pos_r == a2_last;
    wire logic fw_bad = fw_end & (fbad_r | byte_bad);
    wire logic fw_good = fw_end & ~(fbad_r | byte_bad);
    wire logic oof_go = fw_bad & badcnt_r == srom_pkg::OOF_BAD_FRAMES - 3'h1;
    wire logic force_out_of_frame_go = force_out_of_frame_r & frame_end;

    always_comb begin
        case (st_r)
            srom_pkg::FR_SEARCH: st_nxt = hit ? srom_pkg::FR_SYNC : srom_pkg::FR_SEARCH;
            srom_pkg::FR_SYNC: st_nxt = (oof_go | force_out_of_frame_go) ? srom_pkg::FR_SEARCH : srom_pkg::FR_SYNC;
            default: st_nxt = srom_pkg::FR_SEARCH;
        endcase
    end

    wire logic oof_nxt = st_nxt == srom_pkg::FR_SEARCH;
    wire logic [11:0] pos_nxt = hit ? nn + 12'h001 : (stb ? (frame_end ? 12'h000 : pos_r + 12'h001) : pos_r);

    // ------------------------------------------------------------
    // Descrambler and section parity
    // ------------------------------------------------------------
    wire logic [14:0] ks = scr_step(scr_r);
    wire logic in_soh = pos_r < soh_end;
    wire logic [7:0] descr = (in_soh | ctrl_r.descramble_disable) ? cur : cur ^ ks[7:0];
    wire logic [7:0] b1x = bip_prev_r ^ descr;
    wire logic b1_at = stb & syncd & bip_ok_r & pos_r == b1_pos;
    wire logic b1_err = b1_at & (b1x != 8'h00);
    wire logic [3:0] b1_cnt = ctrl_r.parity_word_mode ? {3'h0, b1x != 8'h00} : popcnt(b1x);

    // ------------------------------------------------------------
    // Loss of signal and loss of frame
    // ------------------------------------------------------------
    wire logic zero_viol = zrun_r == LOS_W'(srom_pkg::LOS_CYCLES);
    wire logic fw_ok = hit | fw_good;
    wire logic los_clr = los_r & ~zero_viol & fw_ok & loscnt_r == srom_pkg::LOS_CLEAR_WORDS - 2'h1;
    wire logic los_nxt = zero_viol | (los_r & ~los_clr);
    wire logic lof_flip = oof_r != lof_r && lofcnt_r == LOF_W'(LOF_CYCLES - 1);

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic [5:0] idx = paddr[7:2];
    wire logic setup = psel & ~penable;
    wire logic done = psel & penable & pready;
    wire logic map_ok = paddr[1:0] == 2'h0 &&
                        (idx == srom_pkg::IDX_MASTER_RESET || is_lp(idx) || is_re(idx) ||
                         idx == srom_pkg::IDX_CTRL || idx == srom_pkg::IDX_STATUS);
    wire logic wr = done & pwrite & ~pslverr;
    wire logic rd_status = done & ~pwrite & ~pslverr & idx == srom_pkg::IDX_STATUS;
    wire logic poll_lp = wr & (is_lp(idx) | idx == srom_pkg::IDX_MASTER_RESET);
    wire logic poll_re = wr & (is_re(idx) | idx == srom_pkg::IDX_MASTER_RESET);
    wire logic ctrl_wr = wr & idx == srom_pkg::IDX_CTRL;
    wire logic [7:0] ctrl_rd = ctrl_r & ~(8'h01 << srom_pkg::CTRL_FORCE_OUT_OF_FRAME_POS);
    wire logic [7:0] status_rd = {1'b0, ev_r, los_r, lof_r, oof_r};
    wire logic [31:0] rd_val =
        idx == srom_pkg::IDX_LP_LOW ? {24'h000000, lp_hold_r[7:0]} :
        idx == srom_pkg::IDX_LP_MID ? {24'h000000, lp_hold_r[15:8]} :
        idx == srom_pkg::IDX_LP_HIGH ? {28'h0000000, lp_hold_r[19:16]} :
        idx == srom_pkg::IDX_RE_LOW ? {24'h000000, re_hold_r[7:0]} :
        idx == srom_pkg::IDX_RE_MID ? {24'h000000, re_hold_r[15:8]} :
        idx == srom_pkg::IDX_RE_HIGH ? {28'h0000000, re_hold_r[19:16]} :
        idx == srom_pkg::IDX_CTRL ? {24'h000000, ctrl_rd} :
        idx == srom_pkg::IDX_STATUS ? {24'h000000, status_rd} : 32'h00000000;

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    wire logic [3:0] ev_set = {b1_err, los_nxt != los_r, lof_flip, oof_nxt != oof_r};
    // Only bits seen by the read are cleared, and a new set always wins
    wire logic [3:0] ev_nxt = (ev_r & ~(rd_status ? snap_r : 4'h0)) | ev_set;
    wire logic [3:0] ev_mask = {ctrl_r.section_parity_irq_mask, ctrl_r.signal_loss_irq_mask,
                                ctrl_r.frame_loss_irq_mask, ctrl_r.out_of_frame_irq_mask};

    // ------------------------------------------------------------
    // Framer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= srom_pkg::FR_SEARCH;
            oof_r <= 1'b1;
            pos_r <= 12'h000;
            prev_r <= 8'h00;
            bsr_r <= 16'h0000;
            ph_r <= 3'h0;
        end else begin
            st_r <= st_nxt;
            oof_r <= oof_nxt;
            pos_r <= pos_nxt;
            prev_r <= stb ? cur : prev_r;
            bsr_r <= line_in.strobe ? bwin : bsr_r;
            ph_r <= stb ? 3'h0 : (line_in.strobe ? ph_r + 3'h1 : ph_r);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fbad_r <= 1'b0;
            badcnt_r <= 3'h0;
            force_out_of_frame_r <= 1'b0;
        end else begin
            fbad_r <= hit ? 1'b0 : (stb ? (pos_r == 12'h000 ? byte_bad : fbad_r | byte_bad) : fbad_r);
            badcnt_r <= (hit | fw_good | oof_go) ? 3'h0 : (fw_bad ? badcnt_r + 3'h1 : badcnt_r);
            force_out_of_frame_r <= (ctrl_wr & pwdata[srom_pkg::CTRL_FORCE_OUT_OF_FRAME_POS]) | (force_out_of_frame_r & ~frame_end);
        end
    end

    // ------------------------------------------------------------
    // Stream and parity registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            scr_r <= srom_pkg::SCR_SEED;
            rx_data_out <= 8'h00;
            rx_data_valid <= 1'b0;
            bip_acc_r <= 8'h00;
            bip_prev_r <= 8'h00;
        end else begin
            scr_r <= stb ? (in_soh ? srom_pkg::SCR_SEED : ks[14:8]) : scr_r;
            rx_data_out <= stb ? descr : rx_data_out;
            rx_data_valid <= stb & syncd;
            bip_acc_r <= stb ? (frame_end ? 8'h00 : bip_acc_r ^ cur) : bip_acc_r;
            bip_prev_r <= frame_end ? bip_acc_r ^ cur : bip_prev_r;
        end
    end

    // A parity check needs one whole frame in sync behind it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bip_arm_r <= 1'b0;
            bip_ok_r <= 1'b0;
            b1pend_r <= 4'h0;
            section_parity_error_out <= 1'b0;
        end else begin
            bip_arm_r <= searching ? 1'b0 : (frame_end ? 1'b1 : bip_arm_r);
            bip_ok_r <= searching ? 1'b0 : (frame_end ? bip_arm_r : bip_ok_r);
            b1pend_r <= b1_at ? b1_cnt : (b1pend_r != 4'h0 ? b1pend_r - 4'h1 : 4'h0);
            section_parity_error_out <= b1pend_r != 4'h0;
        end
    end

    // ------------------------------------------------------------
    // Alarm registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            zrun_r <= '0;
            loscnt_r <= 2'h0;
            los_r <= 1'b0;
            lofcnt_r <= '0;
            lof_r <= 1'b0;
        end else begin
            zrun_r <= (stb && cur != 8'h00) ? '0 : (zero_viol ? zrun_r : zrun_r + 1'b1);
            loscnt_r <= (zero_viol | ~los_r | los_clr) ? 2'h0 : (fw_ok ? loscnt_r + 2'h1 : loscnt_r);
            los_r <= los_nxt;
            lofcnt_r <= (oof_r == lof_r || lof_flip) ? '0 : lofcnt_r + 1'b1;
            lof_r <= lof_flip ? ~lof_r : lof_r;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ev_r <= 4'h0;
            section_irq <= 1'b0;
            out_of_frame <= 1'b1;
            frame_loss <= 1'b0;
            signal_loss <= 1'b0;
        end else begin
            ev_r <= ev_nxt;
            section_irq <= (ev_nxt & ev_mask) != 4'h0;
            out_of_frame <= oof_nxt;
            frame_loss <= lof_flip ? ~lof_r : lof_r;
            signal_loss <= los_nxt;
        end
    end

    // ------------------------------------------------------------
    // Error counters
    // ------------------------------------------------------------
    // Polling takes one clock, far inside the allowed settling time
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lp_cnt_r <= '0;
            lp_hold_r <= '0;
            re_cnt_r <= '0;
            re_hold_r <= '0;
        end else begin
            lp_cnt_r <= poll_lp ? CNT_ONE(line_parity_err) : sat_inc(lp_cnt_r, line_parity_err);
            lp_hold_r <= poll_lp ? lp_cnt_r : lp_hold_r;
            re_cnt_r <= poll_re ? CNT_ONE(remote_error) : sat_inc(re_cnt_r, remote_error);
            re_hold_r <= poll_re ? re_cnt_r : re_hold_r;
        end
    end

    function automatic logic [srom_pkg::CNT_W-1:0] CNT_ONE(input logic e);
        return {{(srom_pkg::CNT_W - 1){1'b0}}, e};
    endfunction

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= srom_pkg::CTRL_RST;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            snap_r <= 4'h0;
        end else begin
            ctrl_r <= ctrl_wr ? (pwdata[7:0] & ~(8'h01 << srom_pkg::CTRL_FORCE_OUT_OF_FRAME_POS)) : ctrl_r;
            pready <= setup;
            pslverr <= setup & ~map_ok;
            prdata <= setup ? (map_ok ? rd_val : 32'h00000000) : prdata;
            snap_r <= setup ? ev_r : snap_r;
        end
    end

endmodule // srom_top

// ---- verif/srom_line_model.sv ----
`timescale 1ns/1ps
module srom_line_model (
    // Clock
    input wire logic clk_sys,
    // Control from the bench
    input wire logic run,
    input wire logic zeros,
    // Line stream
    output srom_pkg::srom_line_type line_in
);
    int pos = 0;
    initial line_in = '0;
    always @(posedge clk_sys) begin
        line_in.strobe <= run;
        if (!run) begin
            line_in.data <= ~line_in.data;
        end else begin
            pos <= (pos == int'(srom_pkg::FRAME_LAST_STS1)) ? 0 : pos + 1;
            // Payload stays below the A1 value so no false pattern appears
            line_in.data <= zeros ? 8'h00 : (pos == 0) ? srom_pkg::A1_BYTE : (pos == 1) ? srom_pkg::A2_BYTE :
                8'($urandom_range(8'h7f, 1));
        end
    end
endmodule // srom_line_model

// ---- verif/srom_top_asserts.sv ----
`timescale 1ns/1ps
module srom_top_asserts #(
    parameter int LOF_CYCLES = 20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Line and alarms
    input wire srom_pkg::srom_line_type line_in,
    input wire logic rx_data_valid,
    input wire logic out_of_frame,
    input wire logic frame_loss,
    input wire logic signal_loss
);
    localparam int LOS_MIN = srom_pkg::LOS_CYCLES - 125;
    localparam int LOS_MAX = srom_pkg::LOS_CYCLES + 127;
    logic [31:0] lof_run_r;
    logic [31:0] zero_run_r;
    // ------------------------------------------------------------
    // Persistence counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lof_run_r <= '0;
            zero_run_r <= '0;
        end else begin
            lof_run_r <= (out_of_frame != frame_loss) ? lof_run_r + 1 : '0;
            zero_run_r <= (line_in.strobe && line_in.data != 8'h00) ? '0 : zero_run_r + 1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    chk_setup_ready: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready) else $error("ready held");
    chk_read_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
    chk_unmapped_err: assert property (psel && penable && pready && paddr[7:2] > 6'h11 |-> pslverr)
        else $error("unmapped ok");
    chk_oof_clear: assert property ($fell(out_of_frame) |-> $past(line_in.strobe) &&
        $past(line_in.data) == srom_pkg::A2_BYTE) else $error("oof fell no A2");
    chk_lof_persist: assert property ($changed(frame_loss) |->
        lof_run_r inside {[LOF_CYCLES - 2:LOF_CYCLES + 2]}) else $error("lof timing");
    chk_los_early: assert property ($rose(signal_loss) |-> zero_run_r >= LOS_MIN) else $error("signal loss early");
    chk_los_late: assert property (zero_run_r == LOS_MAX |-> signal_loss) else $error("signal loss late");
    chk_valid_byte: assert property (rx_data_valid |-> $past(line_in.strobe)) else $error("valid without byte");
    chk_reset_state: assert property ($rose(rst_b) |-> out_of_frame && !signal_loss && !pready)
        else $error("reset state");
    cover property ($fell(out_of_frame));
    cover property ($rose(signal_loss));
    cover property ($changed(frame_loss));
    cover property (pslverr);
endmodule // srom_top_asserts

bind srom_top srom_top_asserts #(.LOF_CYCLES(LOF_CYCLES)) u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
    .rx_data_valid(rx_data_valid), .out_of_frame(out_of_frame), .frame_loss(frame_loss), .signal_loss(signal_loss));

// ---- verif/srom_top_test.sv ----
`timescale 1ns/1ps
module srom_top_test;
    logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, run = 1'b0, zeros = 1'b0, lp_err = 1'b0, re_err = 1'b0;
    logic oof, lof, los, irq, rx_valid, b1_out;
    logic [7:0] rx_data, sent;
    logic [1:0] p;
    logic [3:0] flags;
    srom_pkg::srom_line_type line_in;
    int mismatches = 0, checks_done = 0, cnt[2];
    assign flags = {irq, los, lof, oof};
    srom_top #(.LOF_CYCLES(20)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bit_serial_mode(1'b0), .sts3_mode(1'b0), .line_in(line_in), .line_parity_err(lp_err),
        .remote_error(re_err), .rx_data_out(rx_data), .rx_data_valid(rx_valid), .out_of_frame(oof),
        .frame_loss(lof), .signal_loss(los), .section_parity_error_out(b1_out), .section_irq(irq));
    srom_line_model u_line (.clk_sys(clk_sys), .run(run), .zeros(zeros), .line_in(line_in));
    task automatic stop_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd20(input logic [5:0] idx, input int exp, input string nm);
        logic [31:0] b0, b1;
        apb(1'b0, idx, 8'h00);
        b0 = rd;
        apb(1'b0, idx + 6'h1, 8'h00);
        b1 = rd;
        apb(1'b0, idx + 6'h2, 8'h00);
        chk(nm, 32'(exp), {12'h0, rd[3:0], b1[7:0], b0[7:0]});
    endtask
    task automatic wait_lvl(input int b, input logic v, input int lim, input string nm);
        int n;
        n = 0;
        while (flags[b] !== v && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        chk(nm, {31'h0, v}, {31'h0, flags[b]});
    endtask
    initial forever #10 clk_sys = ~clk_sys;
    initial begin
        #400000;
        mismatches++;
        stop_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32));
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (30) @(posedge clk_sys);
        chk("oof_idle", 1, {31'h0, oof});
        chk("lof_declared", 1, {31'h0, lof});
        apb(1'b0, srom_pkg::IDX_CTRL, 8'h00);
        chk("ctrl_reset", {24'h0, srom_pkg::CTRL_RST}, rd);
        sent = 8'($urandom) & 8'hdf;
        apb(1'b1, srom_pkg::IDX_CTRL, sent);
        apb(1'b0, srom_pkg::IDX_CTRL, 8'h00);
        chk("ctrl_rw", {24'h0, sent}, rd & 32'hdf);
        apb(1'b0, 6'h14, 8'h00);
        chk("unmapped", 32'h1, {rd[30:0], err});
        apb(1'b1, srom_pkg::IDX_MASTER_RESET, 8'h00);
        repeat (srom_pkg::POLL_CYCLES) @(posedge clk_sys);
        for (int r = 0; r < 2; r++) begin
            cnt = '{0, 0};
            repeat (150) begin
                @(posedge clk_sys);
                p = 2'($urandom);
                lp_err <= p[0];
                re_err <= p[1];
                cnt[0] += p[0];
                cnt[1] += p[1];
            end
            @(posedge clk_sys);
            lp_err <= 1'b0;
            re_err <= 1'b0;
            if (r == 0) begin
                apb(1'b1, srom_pkg::IDX_LP_MID, 8'h00);
                apb(1'b1, srom_pkg::IDX_RE_HIGH, 8'h00);
            end else begin
                apb(1'b1, srom_pkg::IDX_MASTER_RESET, 8'h00);
            end
            repeat (srom_pkg::POLL_CYCLES) @(posedge clk_sys);
            rd20(srom_pkg::IDX_LP_LOW, cnt[0], "line_parity_count");
            rd20(srom_pkg::IDX_RE_LOW, cnt[1], "remote_error_count");
        end
        apb(1'b1, srom_pkg::IDX_CTRL, 8'h01);
        run <= 1'b1;
        wait_lvl(0, 1'b0, 2000, "oof_removed");
        wait_lvl(3, 1'b1, 4, "irq_oof");
        apb(1'b0, srom_pkg::IDX_STATUS, 8'h00);
        chk("oof_event", 32'h8, rd & 32'h9);
        apb(1'b0, srom_pkg::IDX_STATUS, 8'h00);
        chk("oof_event_clr", 32'h0, rd & 32'h8);
        wait_lvl(3, 1'b0, 4, "irq_clear");
        wait_lvl(1, 1'b0, 60, "lof_removed");
        apb(1'b1, srom_pkg::IDX_CTRL, 8'h40);
        repeat (8) begin
            @(posedge clk_sys);
            sent = line_in.data;
            @(posedge clk_sys);
            chk("rx_bypass", {23'h0, 1'b1, sent}, {23'h0, rx_valid, rx_data});
        end
        apb(1'b1, srom_pkg::IDX_CTRL, 8'h20);
        wait_lvl(0, 1'b1, 900, "forced_oof");
        wait_lvl(0, 1'b0, 1700, "reframe");
        zeros <= 1'b1;
        wait_lvl(2, 1'b1, 1200, "los_set");
        apb(1'b0, srom_pkg::IDX_STATUS, 8'h00);
        chk("los_event", 32'h24, rd & 32'h24);
        zeros <= 1'b0;
        wait_lvl(2, 1'b0, 3000, "los_clear");
        run <= 1'b0;
        stop_test();
    end
endmodule // srom_top_test
